/* File: pkg/remap_rst_cfg.svh */
// Offsets, fields and reset values for the memory remap and reset cause block
`ifndef REMAP_RST_CFG_SVH
`define REMAP_RST_CFG_SVH
`define ADDR_MAP_SEL 4'h0
`define ADDR_RST_STA 4'h1
`define ADDR_RST_CLR 4'h2
`define ADDR_IRQ_STA 4'h3
`define ADDR_IRQ_EN 4'h4
`define ADDR_IRQ_CLR 4'h5
`define ADDR_BOOT 4'h6
`define MAP_SEL_BIT 0
`define CAUSE_POR_BIT 0
`define CAUSE_WDT_BIT 1
`define CAUSE_SW_BIT 2
`define VEC_TOP 32'h0000_0020
`define CAUSE_RESET 3'h0
`define BOOT_CYCLES 8'h10
`define RST_PULSE_CYCLES 4'h4
`endif

/* File: pkg/remap_rst_pkg.sv */
// Types for the memory remap and reset cause block
package remap_rst_pkg;
   typedef enum logic [2:0] {
      ST_KERNEL = 3'b001,
      ST_USER = 3'b010,
      ST_RESET = 3'b100
   } boot_state_e;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;
   typedef struct packed {
      logic [31:0] addr;
      logic valid;
   } fetch_s;
   typedef struct packed {
      logic sram_sel;
      logic flash_sel;
      logic [31:0] addr;
   } route_s;
   typedef struct packed {
      boot_state_e st;
      logic [7:0] boot_cnt;
      logic [3:0] rst_cnt;
      logic map_sel;
      logic [2:0] cause;
      logic [1:0] irq_sta;
      logic [1:0] irq_en;
      logic [7:0] rdata;
      logic irq;
      logic sys_rst;
      logic jump_user;
      logic kernel;
      logic [2:0] por_sy;
      logic [2:0] wdt_sy;
      logic [1:0] bm_sy;
      route_s route;
   } state_s;
endpackage

/* File: verilog/remap_rst.sv */
// Memory remap select, reset cause record and boot sequencing
`timescale 1ns/1ps
`include "remap_rst_cfg.svh"
module remap_rst (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic por_event,
   input wire logic wdt_event,
   input wire logic boot_mode_select,
   input remap_rst_pkg::reg_req_s req,
   input remap_rst_pkg::fetch_s fetch,
   output logic [7:0] rdata,
   output logic irq,
   output logic sys_rst,
   output logic jump_user,
   output logic kernel_active,
   output logic map_sel,
   output remap_rst_pkg::route_s route
);
   import remap_rst_pkg::*;

   state_s s_q;
   state_s s_d;
   logic por_rise;
   logic wdt_rise;
   logic [2:0] clr_mask;
   logic low_region;
   logic [7:0] rd_val;

   // Edge detectors read only the second and third stages of the por_sy and wdt_sy synchronisers
   assign por_rise = s_q.por_sy[1] & ~s_q.por_sy[2];
   assign wdt_rise = s_q.wdt_sy[1] & ~s_q.wdt_sy[2];
   assign clr_mask = req.wdata[2:0];
   assign low_region = fetch.addr <= `VEC_TOP;

   always_comb begin
      rd_val = 8'h00;
      case (req.addr)
         `ADDR_MAP_SEL: rd_val = {7'h00, s_q.map_sel};
         `ADDR_RST_STA: rd_val = {5'h00, s_q.cause};
         `ADDR_IRQ_STA: rd_val = {6'h00, s_q.irq_sta};
         `ADDR_IRQ_EN: rd_val = {6'h00, s_q.irq_en};
         `ADDR_BOOT: rd_val = {5'h00, s_q.st};
         default: rd_val = 8'h00;
      endcase
   end

   always_comb begin
      s_d = s_q;
      s_d.por_sy = {s_q.por_sy[1:0], por_event};
      s_d.wdt_sy = {s_q.wdt_sy[1:0], wdt_event};
      s_d.bm_sy = {s_q.bm_sy[0], boot_mode_select};
      s_d.jump_user = 1'b0;
      s_d.rdata = req.rd ? rd_val : 8'h00;

      // Write to map select; takes effect on a fetch routed in the same cycle
      if (req.wr && req.addr == `ADDR_MAP_SEL) begin
         s_d.map_sel = req.wdata[`MAP_SEL_BIT];
      end

      // Clear first so a coincident set below wins
      if (req.wr && req.addr == `ADDR_RST_CLR) begin
         s_d.cause = s_q.cause & ~clr_mask;
         if ((s_q.cause & ~clr_mask) != 3'h0) begin
            s_d.st = ST_RESET;
            s_d.rst_cnt = `RST_PULSE_CYCLES;
         end
      end
      if (req.wr && req.addr == `ADDR_IRQ_CLR) begin
         s_d.irq_sta = s_q.irq_sta & ~req.wdata[1:0];
      end
      if (req.wr && req.addr == `ADDR_IRQ_EN) begin
         s_d.irq_en = req.wdata[1:0];
      end

      if (req.wr && req.addr == `ADDR_RST_STA &&
          req.wdata[`CAUSE_SW_BIT]) begin
         s_d.cause[`CAUSE_SW_BIT] = 1'b1;
         s_d.st = ST_RESET;
         s_d.rst_cnt = `RST_PULSE_CYCLES;
      end
      if (wdt_rise) begin
         s_d.cause[`CAUSE_WDT_BIT] = 1'b1;
         s_d.st = ST_RESET;
         s_d.rst_cnt = `RST_PULSE_CYCLES;
      end
      if (por_rise) begin
         s_d.cause[`CAUSE_POR_BIT] = 1'b1;
         s_d.st = ST_RESET;
         s_d.rst_cnt = `RST_PULSE_CYCLES;
      end
      // Interrupt status: bit 0 power-on or watchdog reset cause, bit 1 boot done
      if (por_rise || wdt_rise) begin
         s_d.irq_sta[0] = 1'b1;
      end

      case (s_q.st)
         ST_KERNEL: begin
            s_d.sys_rst = 1'b0;
            if (s_q.boot_cnt != 8'h00) begin
               s_d.boot_cnt = s_q.boot_cnt - 8'h01;
            end else if (s_q.bm_sy[1]) begin
               s_d.st = ST_USER;
               s_d.jump_user = 1'b1;
               s_d.irq_sta[1] = 1'b1;
            end
         end
         ST_USER: s_d.sys_rst = 1'b0;
         ST_RESET: begin
            // Internal reset pulse restores the flash mapping
            s_d.sys_rst = 1'b1;
            s_d.map_sel = 1'b0;
            s_d.boot_cnt = `BOOT_CYCLES;
            if (s_q.rst_cnt != 4'h0) begin
               s_d.rst_cnt = s_q.rst_cnt - 4'h1;
            end else begin
               s_d.st = ST_KERNEL;
            end
         end
         default: s_d.st = ST_KERNEL;
      endcase
      // A new power-on or watchdog cause also clears map_sel, after the state case above
      if (por_rise || wdt_rise) begin
         s_d.map_sel = 1'b0;
      end

      // Registered so the state decode reaches the pin glitch free
      s_d.kernel = s_d.st == ST_KERNEL;
      s_d.irq = |(s_d.irq_sta & s_d.irq_en);

      // Route only the vector window through the mirror
      s_d.route.addr = fetch.addr;
      s_d.route.sram_sel = fetch.valid & low_region & s_d.map_sel;
      s_d.route.flash_sel = fetch.valid & ~(low_region & s_d.map_sel);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         // External reset restarts the kernel with the flash mirrored
         s_q.st <= ST_KERNEL;
         s_q.boot_cnt <= `BOOT_CYCLES;
         s_q.rst_cnt <= 4'h0;
         s_q.map_sel <= 1'b0;
         // An external-only reset leaves no cause flag behind
         s_q.cause <= `CAUSE_RESET;
         s_q.irq_sta <= 2'h0;
         s_q.irq_en <= 2'h0;
         s_q.rdata <= 8'h00;
         s_q.irq <= 1'b0;
         s_q.sys_rst <= 1'b0;
         s_q.jump_user <= 1'b0;
         s_q.kernel <= 1'b1;
         // Synchronisers start at the idle low level: no false edge
         s_q.por_sy <= 3'h0;
         s_q.wdt_sy <= 3'h0;
         s_q.bm_sy <= 2'h0;
         s_q.route.sram_sel <= 1'b0;
         s_q.route.flash_sel <= 1'b0;
         s_q.route.addr <= 32'h0000_0000;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata = s_q.rdata;
   assign irq = s_q.irq;
   assign sys_rst = s_q.sys_rst;
   assign jump_user = s_q.jump_user;
   assign kernel_active = s_q.kernel;
   assign map_sel = s_q.map_sel;
   assign route = s_q.route;
endmodule

/* File: test/cpu_model.sv */
// Processor side: register accesses and memory fetches
`timescale 1ns/1ps
module cpu_model (
   input wire logic mclk,
   input wire logic [7:0] rdata,
   output remap_rst_pkg::reg_req_s req,
   output remap_rst_pkg::fetch_s fetch
);
   import remap_rst_pkg::*;
   initial begin
      req = '0;
      fetch = '0;
   end
   // Released data is inverted so stale values cannot pass
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk);
      req <= '{a, ~d, 1'b0, 1'b0};
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge mclk);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge mclk);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask
   // Code runs above the mirror, so only go() touches low memory
   task automatic go(input logic [31:0] a);
      @(posedge mclk);
      fetch <= '{a, 1'b1};
      @(posedge mclk);
      fetch <= '{32'h0008_0020, 1'b0};
   endtask
endmodule

/* File: test/remap_rst_monitor.sv */
// Port checks for the remap and reset cause block
`timescale 1ns/1ps
module remap_rst_monitor (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic por_event,
   input wire logic wdt_event,
   input remap_rst_pkg::reg_req_s req,
   input remap_rst_pkg::fetch_s fetch,
   input wire logic sys_rst,
   input wire logic jump_user,
   input wire logic kernel_active,
   input wire logic map_sel,
   input remap_rst_pkg::route_s route
);
   import remap_rst_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_vec_route: assert property (fetch.valid && fetch.addr <= 32'h20
      |=> route.sram_sel == map_sel) else $error("vector route");
   a_rst_unmap: assert property (sys_rst |=> !map_sel)
      else $error("map kept in reset");
   a_rst_width: assert property ($rose(sys_rst)
      |-> sys_rst[*5] ##1 !sys_rst) else $error("reset width");
   a_por_reset: assert property ($rose(por_event) |-> ##[1:6] sys_rst)
      else $error("no power-on reset");
   a_wdt_reset: assert property ($rose(wdt_event) |-> ##[1:6] sys_rst)
      else $error("no watchdog reset");
   a_sw_reset: assert property (req.wr && req.addr == 4'h1
      && req.wdata[2] |-> ##[1:6] sys_rst) else $error("no soft reset");
   a_map_write: assert property (req.wr && req.addr == 4'h0
      |=> map_sel == $past(req.wdata[0])) else $error("map write");
   a_jump_pulse: assert property (jump_user
      |=> !jump_user && !kernel_active) else $error("jump pulse");
endmodule
bind remap_rst remap_rst_monitor u_mon (.*);

/* File: test/remap_rst_tb_top.sv */
// Self-checking bench for the remap and reset cause block
`timescale 1ns/1ps
`include "remap_rst_cfg.svh"
module remap_rst_tb_top;
   import remap_rst_pkg::*;
   logic mclk = 0, rst_n = 0, por_event = 0, wdt_event = 0;
   logic boot_mode_select = 1;
   reg_req_s req;
   fetch_s fetch;
   logic [7:0] rdata, v;
   logic irq, sys_rst, jump_user, kernel_active, map_sel;
   route_s route;
   int bad_count = 0, total_checks = 0, cyc = 0;
   remap_rst u_dut (.*);
   cpu_model u_cpu (.*);
   initial forever #2.5 mclk = ~mclk;
   task automatic chk(string n, logic [7:0] e, logic [7:0] s);
      total_checks++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rchk(string n, logic [3:0] a, logic [7:0] e);
      u_cpu.rd(a, v);
      chk(n, e, v);
   endtask
   // Bounded wait for the hand-over that ends a reset event while boot_mode_select is high
   task automatic settle;
      int n;
      n = 0;
      while (jump_user !== 1'b1 && n < 100) begin
         @(posedge mclk);
         n++;
      end
      chk("jump", 1, jump_user);
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         give_verdict;
      end
   end
   initial begin
      repeat (6) @(posedge mclk);
      rst_n <= 1;
      rchk("cause", `ADDR_RST_STA, 8'h00);
      rchk("map", `ADDR_MAP_SEL, 8'h00);
      chk("kernel", 1, kernel_active);
      u_cpu.wr(`ADDR_MAP_SEL, 8'h01);
      rchk("map", `ADDR_MAP_SEL, 8'h01);
      u_cpu.go(32'h20);
      #1 chk("sram", 1, route.sram_sel);
      chk("flash", 0, route.flash_sel);
      u_cpu.go(32'h24);
      #1 chk("sram", 0, route.sram_sel);
      chk("flash", 1, route.flash_sel);
      chk("addr", 8'h24, route.addr[7:0]);
      u_cpu.wr(`ADDR_MAP_SEL, 8'h00);
      u_cpu.go(32'h0);
      #1 chk("sram", 0, route.sram_sel);
      u_cpu.wr(`ADDR_MAP_SEL, 8'h01);
      u_cpu.wr(`ADDR_IRQ_EN, 8'h01);
      por_event <= 1;
      settle;
      por_event <= 0;
      chk("map", 0, map_sel);
      chk("sys_rst", 0, sys_rst);
      rchk("boot", `ADDR_BOOT, 8'h02);
      @(posedge mclk);
      #1 chk("rdata", 0, rdata);
      rchk("cause", `ADDR_RST_STA, 8'h01);
      chk("irq", 1, irq);
      u_cpu.wr(`ADDR_IRQ_EN, 8'h00);
      rchk("irq_sta", `ADDR_IRQ_STA, 8'h03);
      chk("irq", 0, irq);
      u_cpu.wr(`ADDR_IRQ_EN, 8'h01);
      u_cpu.wr(`ADDR_IRQ_CLR, 8'h01);
      u_cpu.wr(`ADDR_RST_CLR, 8'h01);
      rchk("cause", `ADDR_RST_STA, 8'h00);
      chk("irq", 0, irq);
      wdt_event <= 1;
      settle;
      wdt_event <= 0;
      rchk("cause", `ADDR_RST_STA, 8'h02);
      chk("irq", 1, irq);
      u_cpu.wr(`ADDR_RST_CLR, 8'h00);
      settle;
      rchk("cause", `ADDR_RST_STA, 8'h02);
      u_cpu.wr(`ADDR_RST_CLR, 8'h02);
      boot_mode_select <= 0;
      u_cpu.wr(`ADDR_RST_STA, 8'h04);
      repeat (30) @(posedge mclk);
      #1 chk("kernel", 1, kernel_active);
      @(posedge mclk);
      boot_mode_select <= 1;
      settle;
      rchk("cause", `ADDR_RST_STA, 8'h04);
      u_cpu.wr(`ADDR_MAP_SEL, 8'h01);
      rst_n <= 0;
      repeat (2) @(posedge mclk);
      rst_n <= 1;
      #1 chk("map", 0, map_sel);
      rchk("cause", `ADDR_RST_STA, 8'h00);
      settle;
      rchk("unmapped", 4'hF, 8'h00);
      give_verdict;
   end
endmodule
